// >>> common/mnse_pkg.sv
package mnse_pkg;
	// secured packet layout, in bytes
	localparam int HDR_LEN = 14;
	localparam int APS_HDR_LEN = 5;
	localparam int TAG_LEN = 4;
	localparam logic [7:0] NWK_OVH = 8'h12;
	localparam logic [7:0] APS_OVH = 8'h09;
	localparam logic [7:0] MAX_PL_DEF = 8'h54;
	localparam logic [31:0] CTR_MAX = 32'hffffffff;
	localparam logic [7:0] APS_HDR_CTL = 8'h21;
	// flag byte of the network header
	localparam int FLG_APS = 0;
	localparam int FLG_BCAST = 1;
	// packet types from the host
	localparam logic [2:0] FT_DATA = 3'h0;
	localparam logic [2:0] FT_ROUTE = 3'h1;
	localparam logic [2:0] FT_APSCMD = 3'h2;
	localparam logic [2:0] FT_ZDOCMD = 3'h3;
	localparam logic [2:0] FT_MAC = 3'h4;
	// stand-in hash and key generator seeds, arbitrary values
	localparam logic [31:0] CPH_SEED = 32'h5a3c96e1;
	localparam logic [127:0] LFSR_SEED = 128'h0123456789abcdef_fedcba9876543210;
	typedef enum logic [2:0] {
		TX_IDLE, TX_HDR, TX_AHDR, TX_BODY, TX_ATAG, TX_NTAG, TX_PLAIN, TX_DROP
	} mnse_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE, RX_HDR, RX_BODY, RX_CHK, RX_PLAIN
	} mnse_rx_st_t;
endpackage

// >>> rtl/mnse_cipher.sv
`timescale 1ns/1ps
// keyed byte-serial keystream and integrity tag; stands in for the aes core
module mnse_cipher import mnse_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic init,
	input wire logic [127:0] key,
	input wire logic [111:0] nonce,
	input wire logic step,
	input wire logic [7:0] din,
	// results
	output logic [7:0] ks,
	output logic [31:0] tag
);
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] kst;
		logic [1:0] idx;
	} mnse_cph_t;
	mnse_cph_t q, d;
	logic [31:0] seed;
	logic [31:0] kw;

	always_comb begin
		d = q;
		seed = key[31:0] ^ key[63:32] ^ key[95:64] ^ key[127:96] ^ nonce[31:0]
			^ nonce[63:32] ^ nonce[95:64] ^ {16'h0, nonce[111:96]} ^ CPH_SEED;
		kw = key[{q.idx, 5'h0} +: 32];
		if (init) begin
			d.acc = seed;
			d.kst = {seed[15:0], seed[31:16]} ^ key[31:0];
			d.idx = 2'h0;
		end else if (step) begin
			d.acc = {q.acc[28:0], q.acc[31:29]} ^ ({24'h0, din} + kw);
			d.kst = ({q.kst[26:0], q.kst[31:27]} + kw) ^ q.acc;
			d.idx = q.idx + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ks = q.kst[7:0] ^ q.acc[15:8];
	assign tag = q.acc ^ q.kst;
endmodule

// >>> rtl/mnse_engine.sv
`timescale 1ns/1ps
// Overview of operation
// - 32-bit frame counter goes in each secured header, plus one per transmission.
// - keep last counter per neighbour; drop received packets with a lower counter.
// - counter stops at all ones; further secured transmissions are refused.
// - replacing the network key clears own counter and every neighbour counter that a packet accepted in that cycle does not rewrite.
// - hash over headers and data appended as a 4-byte integrity tag.
// - receiver recomputes network tag and drops the packet on mismatch.
// - each hop decrypts, checks, and re-secures relayed packets with its own counter.
// - network security costs 18 bytes: counter, address, tag, two more.
// - all data and command traffic encrypted; mac frames like beacons left plain.
// - end-to-end aps encryption chosen per packet.
// - broadcasts never get aps encryption.
// - aps adds its own 4-byte tag; destination drops on mismatch.
// - aps applied at source, removed at destination; payload shrinks 9 bytes.
// - coordinator picks the network key, preset or random.
// - nonzero link key setting: joiner with link key gets wrapped network key, else is denied.
// - security on when enable setting is 1; traffic encrypted, payload shrinks.
// - applied change of enable setting leaves the network, then rejoins.
// - zero network key setting means a random key, nonzero used directly.
// - key update adopts key, bumps key sequence, clears counters other than a slot a packet accepted that cycle rewrites.
// - zero link key setting admits joiners without link key, key in clear.
module mnse_engine import mnse_pkg::*; #(
	parameter int NBR_N = 8,
	parameter logic [7:0] MAX_PL = MAX_PL_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic isCoordinator,
	input wire logic [63:0] ownAddr,
	input wire logic securityEnableSetting,
	input wire logic applyChangesCommand,
	input wire logic [127:0] networkKeySetting,
	input wire logic networkKeyLoad,
	input wire logic [127:0] linkKeySetting,
	// host transmit stream
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txLast,
	input wire logic [2:0] txType,
	input wire logic txAps,
	input wire logic txBcast,
	output logic txReady,
	// air transmit stream
	output logic airValid,
	output logic [7:0] airData,
	output logic airLast,
	input wire logic airReady,
	// air receive stream
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxLast,
	input wire logic rxIsDest,
	// host receive stream and verdict
	output logic rxOutValid,
	output logic [7:0] rxOutData,
	output logic rxDone,
	output logic rxDrop,
	output logic rxRelay,
	// key delivery to joiners
	input wire logic joinReq,
	input wire logic joinHasLinkKey,
	output logic keyDlvValid,
	output logic [127:0] keyDlvData,
	output logic keyDlvEnc,
	output logic joinDenied,
	// status
	output logic secEnabled,
	output logic leaveNet,
	output logic rejoinNet,
	output logic [31:0] txCtr,
	output logic [7:0] keySeq,
	output logic txExhausted,
	output logic txRefused,
	output logic [7:0] maxPayloadQuery,
	output logic [7:0] maxPayloadApsQuery
);
	localparam int SLOT_W = (NBR_N > 1) ? $clog2(NBR_N) : 1;
	typedef struct packed {
		logic secEn, leave, rejoin, ctrExh, txRef;
		logic [127:0] netKey, lfsr, dlvD;
		logic [7:0] keySeq, maxPl, maxPlAps;
		logic [31:0] txCtr, nCtr;
		logic dlvV, dlvE, deny;
		mnse_tx_st_t txSt;
		logic [3:0] txIdx;
		logic hV, hL, txRdy, open, tAps, tBc;
		logic [7:0] hD;
		logic [2:0] tType;
		logic aV, aL;
		logic [7:0] aD;
		mnse_rx_st_t rxSt;
		logic [3:0] rIdx;
		logic [31:0] rCtr;
		logic [63:0] rSrc;
		logic [7:0] rSeq, rFlg;
		logic rDest, bad, replay;
		logic [3:0][7:0] sh, dsh;
		logic [2:0] sCnt, dCnt, aIdx;
		logic oV, done, drop, relay;
		logic [7:0] oD;
		logic [NBR_N-1:0][31:0] nbr;
	} mnse_st_t;
	mnse_st_t q, d;

	logic emit, last, apsEnc, nwkEnc, sec, apsOn, mis;
	logic [7:0] pb, apsOut, nwkOut, x, dec, y;
	logic [7:0] tnKs, taKs, rnKs, raKs;
	logic [31:0] tnTag, taTag, rnTag, raTag;
	logic tnInit, taInit, tnStep, taStep, rnInit, rnStep, raStep;
	logic [111:0] txNonce, rxNonce, hdrVec;
	logic [39:0] ahdrVec;
	logic [7:0] flg;
	logic [SLOT_W-1:0] slot;

	always_comb begin
		d = q;
		{emit, last, apsEnc, nwkEnc, mis} = '0;
		{tnInit, taInit, tnStep, taStep, rnInit, rnStep, raStep} = '0;
		{pb, x, dec, y} = '0;
		d.lfsr = {q.lfsr[126:0], q.lfsr[127] ^ q.lfsr[125] ^ q.lfsr[100] ^ q.lfsr[98]};
		{d.leave, d.txRef, d.dlvV, d.deny, d.oV, d.done, d.drop, d.relay} = '0;
		d.rejoin = q.leave;
		// network key replacement or security restart clears all counters except the slot a receive verdict accepts in that cycle
		if (networkKeyLoad) begin
			d.netKey = (networkKeySetting == 128'h0) ? q.lfsr : networkKeySetting;
			d.keySeq = q.keySeq + 8'h1;
			d.txCtr = '0;
			d.nbr = '0;
		end
		if (applyChangesCommand && securityEnableSetting != q.secEn) begin
			d.secEn = securityEnableSetting;
			d.leave = 1'b1;
			d.txCtr = '0;
			d.nbr = '0;
		end
		d.maxPl = d.secEn ? MAX_PL - NWK_OVH : MAX_PL;
		d.maxPlAps = d.maxPl - APS_OVH;
		d.ctrExh = (d.txCtr == CTR_MAX);
		// only the coordinator hands out the network key
		if (joinReq && isCoordinator) begin
			if (linkKeySetting == 128'h0) begin
				d.dlvV = 1'b1;
				d.dlvD = q.netKey;
				d.dlvE = 1'b0;
			end else if (joinHasLinkKey) begin
				d.dlvV = 1'b1;
				d.dlvD = q.netKey ^ linkKeySetting;
				d.dlvE = 1'b1;
			end else begin
				d.deny = 1'b1;
			end
		end

		// transmit: one-byte input hold, header, aps layer, tags
		if (txValid && q.txRdy) begin
			d.hV = 1'b1;
			d.hD = txData;
			d.hL = txLast;
			d.open = !txLast;
			if (!q.open) begin
				d.tType = txType;
				d.tAps = txAps && !txBcast;
				d.tBc = txBcast;
			end
		end
		if (airReady) begin
			d.aV = 1'b0;
		end
		sec = q.secEn && q.tType != FT_MAC;
		apsOn = q.tAps;
		flg = {6'h0, q.tBc, apsOn};
		hdrVec = {flg, q.keySeq, ownAddr, q.nCtr};
		ahdrVec = {q.nCtr, APS_HDR_CTL};
		txNonce = {ownAddr, q.txCtr, q.keySeq, flg};
		case (q.txSt)
			TX_IDLE: begin
				// a packet never starts in the cycle that clears the counter
				if (q.hV && !networkKeyLoad && !applyChangesCommand) begin
					if (!sec) begin
						d.txSt = TX_PLAIN;
					end else if (q.ctrExh) begin
						d.txSt = TX_DROP;
						d.txRef = 1'b1;
					end else begin
						d.nCtr = q.txCtr;
						d.txCtr = q.txCtr + 32'h1;
						tnInit = 1'b1;
						taInit = apsOn;
						d.txIdx = 4'h0;
						d.txSt = TX_HDR;
					end
				end
			end
			TX_HDR: begin
				emit = !q.aV || airReady;
				pb = hdrVec[{q.txIdx, 3'h0} +: 8];
				if (emit) begin
					d.txIdx = (q.txIdx == 4'(HDR_LEN - 1)) ? 4'h0 : q.txIdx + 4'h1;
					if (q.txIdx == 4'(HDR_LEN - 1)) begin
						d.txSt = apsOn ? TX_AHDR : TX_BODY;
					end
				end
			end
			TX_AHDR: begin
				emit = !q.aV || airReady;
				nwkEnc = 1'b1;
				pb = ahdrVec[{q.txIdx[2:0], 3'h0} +: 8];
				taStep = emit;
				if (emit) begin
					d.txIdx = (q.txIdx == 4'(APS_HDR_LEN - 1)) ? 4'h0 : q.txIdx + 4'h1;
					if (q.txIdx == 4'(APS_HDR_LEN - 1)) begin
						d.txSt = TX_BODY;
					end
				end
			end
			TX_BODY: begin
				emit = q.hV && (!q.aV || airReady);
				nwkEnc = 1'b1;
				apsEnc = apsOn;
				pb = q.hD;
				taStep = emit && apsOn;
				if (emit) begin
					d.hV = d.hV && (txValid && q.txRdy);
					d.txSt = q.hL ? (apsOn ? TX_ATAG : TX_NTAG) : TX_BODY;
				end
			end
			TX_ATAG: begin
				emit = !q.aV || airReady;
				nwkEnc = 1'b1;
				pb = taTag[{q.txIdx[1:0], 3'h0} +: 8];
				if (emit) begin
					d.txIdx = q.txIdx + 4'h1;
					if (q.txIdx == 4'(TAG_LEN - 1)) begin
						d.txIdx = 4'h0;
						d.txSt = TX_NTAG;
					end
				end
			end
			TX_NTAG: begin
				emit = !q.aV || airReady;
				pb = tnTag[{q.txIdx[1:0], 3'h0} +: 8];
				last = q.txIdx == 4'(TAG_LEN - 1);
				if (emit) begin
					d.txIdx = last ? 4'h0 : q.txIdx + 4'h1;
					d.txSt = last ? TX_IDLE : TX_NTAG;
				end
			end
			TX_PLAIN: begin
				emit = q.hV && (!q.aV || airReady);
				pb = q.hD;
				last = q.hL;
				if (emit) begin
					d.hV = 1'b0;
					d.txSt = q.hL ? TX_IDLE : TX_PLAIN;
				end
			end
			TX_DROP: begin
				if (q.hV) begin
					d.hV = 1'b0;
					d.txSt = q.hL ? TX_IDLE : TX_DROP;
				end
			end
			default: d.txSt = TX_IDLE;
		endcase
		apsOut = pb ^ (apsEnc ? taKs : 8'h0);
		nwkOut = apsOut ^ (nwkEnc ? tnKs : 8'h0);
		tnStep = emit && nwkEnc;
		if (emit) begin
			d.aV = 1'b1;
			d.aD = nwkOut;
			d.aL = last;
		end
		// the hold slot frees only when emptied, so the host never overruns it
		if (emit && q.txSt inside {TX_BODY, TX_PLAIN}) begin
			d.hV = 1'b0;
		end
		if (q.txSt == TX_DROP && q.hV) begin
			d.hV = 1'b0;
		end
		d.txRdy = !d.hV;

		// receive: header capture, 4-byte tag delay, verdict one cycle after last
		slot = q.rSrc[SLOT_W-1:0];
		rxNonce = {q.rSrc, q.rCtr, q.rSeq, rxData};
		y = q.dsh[3];
		case (q.rxSt)
			RX_IDLE: begin
				if (rxValid && q.secEn) begin
					d.rCtr = {rxData, q.rCtr[31:8]};
					d.rIdx = 4'h1;
					{d.bad, d.replay, d.sCnt, d.dCnt, d.aIdx} = '0;
					d.rxSt = RX_HDR;
					if (rxLast) begin
						{d.done, d.drop, d.rxSt} = {2'b11, RX_IDLE};
					end
				end else if (rxValid) begin
					{d.oV, d.oD} = {1'b1, rxData};
					d.done = rxLast;
					d.rxSt = rxLast ? RX_IDLE : RX_PLAIN;
				end
			end
			RX_PLAIN: begin
				if (rxValid) begin
					{d.oV, d.oD, d.done} = {1'b1, rxData, rxLast};
					d.rxSt = rxLast ? RX_IDLE : RX_PLAIN;
				end
			end
			RX_HDR: begin
				if (rxValid) begin
					d.rIdx = q.rIdx + 4'h1;
					if (q.rIdx < 4'h4) begin
						d.rCtr = {rxData, q.rCtr[31:8]};
					end else if (q.rIdx < 4'hc) begin
						d.rSrc = {rxData, q.rSrc[63:8]};
					end else if (q.rIdx == 4'hc) begin
						d.rSeq = rxData;
					end else begin
						d.rFlg = rxData;
						d.rDest = rxIsDest;
						d.replay = q.rCtr < q.nbr[slot];
						rnInit = 1'b1;
						d.rxSt = RX_BODY;
					end
					if (rxLast) begin
						{d.done, d.drop, d.rxSt} = {2'b11, RX_IDLE};
					end
				end
			end
			RX_BODY: begin
				if (rxValid) begin
					d.sh = {q.sh[2:0], rxData};
					if (q.sCnt == 3'h4) begin
						x = q.sh[3];
						rnStep = 1'b1;
						dec = x ^ rnKs;
						d.dsh = {q.dsh[2:0], dec};
						if (q.rFlg[FLG_APS] && q.rDest) begin
							if (q.dCnt == 3'h4) begin
								raStep = 1'b1;
								d.aIdx = (q.aIdx == 3'h5) ? q.aIdx : q.aIdx + 3'h1;
								d.oV = q.aIdx == 3'h5;
								d.oD = y ^ raKs;
							end else begin
								d.dCnt = q.dCnt + 3'h1;
							end
						end else begin
							{d.oV, d.oD} = {1'b1, dec};
						end
					end else begin
						d.sCnt = q.sCnt + 3'h1;
					end
					if (rxLast) begin
						d.bad = q.sCnt < 3'h3;
						d.rxSt = RX_CHK;
					end
				end
			end
			RX_CHK: begin
				mis = rnTag != {q.sh[0], q.sh[1], q.sh[2], q.sh[3]};
				if (q.rFlg[FLG_APS] && q.rDest) begin
					mis = mis || q.dCnt != 3'h4
						|| raTag != {q.dsh[0], q.dsh[1], q.dsh[2], q.dsh[3]};
				end
				d.done = 1'b1;
				d.drop = q.bad || q.replay || mis;
				d.relay = !d.drop && !q.rDest;
				if (!d.drop) begin
					d.nbr[slot] = q.rCtr;
				end
				d.rxSt = RX_IDLE;
			end
			default: d.rxSt = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.lfsr <= LFSR_SEED;
			q.maxPl <= MAX_PL;
			q.maxPlAps <= MAX_PL - APS_OVH;
			q.txRdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// network layer uses the network key, aps layer the link key
	mnse_cipher uTxNwk (.clk(clk), .rst_n(rst_n), .init(tnInit), .key(q.netKey),
		.nonce(txNonce), .step(tnStep), .din(nwkOut), .ks(tnKs), .tag(tnTag));
	mnse_cipher uTxAps (.clk(clk), .rst_n(rst_n), .init(taInit), .key(linkKeySetting),
		.nonce(txNonce), .step(taStep), .din(apsOut), .ks(taKs), .tag(taTag));
	mnse_cipher uRxNwk (.clk(clk), .rst_n(rst_n), .init(rnInit), .key(q.netKey),
		.nonce(rxNonce), .step(rnStep), .din(x), .ks(rnKs), .tag(rnTag));
	mnse_cipher uRxAps (.clk(clk), .rst_n(rst_n), .init(rnInit), .key(linkKeySetting),
		.nonce(rxNonce), .step(raStep), .din(y), .ks(raKs), .tag(raTag));

	assign txReady = q.txRdy;
	assign airValid = q.aV;
	assign airData = q.aD;
	assign airLast = q.aL;
	assign rxOutValid = q.oV;
	assign rxOutData = q.oD;
	assign rxDone = q.done;
	assign rxDrop = q.drop;
	assign rxRelay = q.relay;
	assign keyDlvValid = q.dlvV;
	assign keyDlvData = q.dlvD;
	assign keyDlvEnc = q.dlvE;
	assign joinDenied = q.deny;
	assign secEnabled = q.secEn;
	assign leaveNet = q.leave;
	assign rejoinNet = q.rejoin;
	assign txCtr = q.txCtr;
	assign keySeq = q.keySeq;
	assign txExhausted = q.ctrExh;
	assign txRefused = q.txRef;
	assign maxPayloadQuery = q.maxPl;
	assign maxPayloadApsQuery = q.maxPlAps;
endmodule

// >>> test/mnse_engine_checker.sv
`timescale 1ns/1ps
module mnse_engine_checker import mnse_pkg::*; #(
	parameter logic [7:0] MAX_PL = MAX_PL_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// settings
	input wire logic securityEnableSetting,
	input wire logic applyChangesCommand,
	input wire logic networkKeyLoad,
	// status
	input wire logic secEnabled,
	input wire logic leaveNet,
	input wire logic rejoinNet,
	input wire logic [31:0] txCtr,
	input wire logic [7:0] keySeq,
	input wire logic [7:0] maxPayloadQuery,
	input wire logic [7:0] maxPayloadApsQuery
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	ctr_step_a: assert property (
		$changed(txCtr) |-> txCtr == $past(txCtr) + 32'h1 || txCtr == 32'h0)
		else $error("frame counter step");
	// a saturated counter may only leave the top through a key or security change
	ctr_hold_a: assert property (
		txCtr == CTR_MAX && !networkKeyLoad && !applyChangesCommand |=> txCtr == CTR_MAX)
		else $error("frame counter left its maximum");
	key_clear_a: assert property (
		networkKeyLoad |=> txCtr == 32'h0 && keySeq == $past(keySeq) + 8'h1)
		else $error("key load did not clear counter");
	key_seq_a: assert property (
		$changed(keySeq) |-> $past(networkKeyLoad))
		else $error("key sequence moved without load");
	sec_apply_a: assert property (
		applyChangesCommand && securityEnableSetting != secEnabled
		|=> secEnabled == $past(securityEnableSetting) && leaveNet && txCtr == 32'h0)
		else $error("applied security change");
	leave_rejoin_a: assert property (
		leaveNet |=> rejoinNet && !leaveNet)
		else $error("rejoin after leave");
	// queries are registered with the security state, so they agree every cycle
	pl_size_a: assert property (
		maxPayloadQuery == (secEnabled ? MAX_PL - NWK_OVH : MAX_PL))
		else $error("payload size");
	aps_size_a: assert property (
		maxPayloadApsQuery == maxPayloadQuery - APS_OVH)
		else $error("aps payload size");
	cover property (leaveNet ##1 rejoinNet);
	cover property (networkKeyLoad ##1 keySeq != 8'h0);
	cover property ($rose(secEnabled));
endmodule

// >>> test/mnse_air_node.sv
`timescale 1ns/1ps
// neighbour node: takes air bytes with stalls and replays packets into the receiver
module mnse_air_node (
	// clock
	input wire logic clk,
	// air from the engine
	input wire logic airValid,
	input wire logic [7:0] airData,
	input wire logic airLast,
	output logic airReady,
	// air into the engine
	output logic rxValid,
	output logic [7:0] rxData,
	output logic rxLast
);
	logic [1:0] phase = 2'h0;
	logic [7:0] cur[$], last[$];
	initial begin
		rxValid = 1'b0;
		rxData = 8'h00;
		rxLast = 1'b0;
	end
	// one stall in four keeps the engine holding bytes mid-packet
	assign airReady = phase != 2'h3;
	always @(posedge clk) begin
		phase <= phase + 2'h1;
		if (airValid && airReady) begin
			cur.push_back(airData);
			if (airLast) begin
				last = cur;
				cur.delete();
			end
		end
	end
	task send(input logic [7:0] q[$]);
		foreach (q[j]) begin
			@(posedge clk);
			rxValid <= 1'b1;
			rxData <= q[j];
			rxLast <= j == q.size() - 1;
		end
		@(posedge clk);
		rxValid <= 1'b0;
		rxLast <= 1'b0;
		// idle line shows the inverse so a stale byte never passes for data
		rxData <= ~rxData;
	endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb import mnse_pkg::*; ();
	localparam logic [127:0] NK = 128'h2468ace0;
	localparam logic [127:0] LK = 128'h1357;
	logic clk, rst_n = 1'b0, isCoordinator = 1'b1, securityEnableSetting = 1'b0;
	logic applyChangesCommand = 1'b0, networkKeyLoad = 1'b0, joinReq = 1'b0;
	logic joinHasLinkKey = 1'b0, txValid = 1'b0, txLast = 1'b0, txAps = 1'b0;
	logic txBcast = 1'b0, rxIsDest = 1'b0;
	logic [63:0] ownAddr = 64'h1122334455667788;
	logic [127:0] networkKeySetting = 128'h0, linkKeySetting = 128'h0, keyDlvData, dlvD;
	logic [7:0] txData = 8'h00, airData, rxData, rxOutData, keySeq, maxPayloadQuery;
	logic [7:0] maxPayloadApsQuery, outQ[$], a[$], b[$], c[$], p[$];
	logic [2:0] txType = 3'h0;
	logic txReady, airValid, airLast, airReady, rxValid, rxLast, rxOutValid, rxDone, rxDrop;
	logic rxRelay, keyDlvValid, keyDlvEnc, joinDenied, secEnabled, leaveNet, rejoinNet;
	logic txExhausted, txRefused, dlvV, dlvE, den, dropS, relS, rejS, refS;
	logic [31:0] txCtr;
	int evN = 0, evO, miscompares = 0, checks = 0, i;
	mnse_engine dut (
		.clk(clk), .rst_n(rst_n), .isCoordinator(isCoordinator), .ownAddr(ownAddr),
		.securityEnableSetting(securityEnableSetting), .applyChangesCommand(applyChangesCommand),
		.networkKeySetting(networkKeySetting), .networkKeyLoad(networkKeyLoad),
		.linkKeySetting(linkKeySetting), .txValid(txValid), .txData(txData), .txLast(txLast),
		.txType(txType), .txAps(txAps), .txBcast(txBcast), .txReady(txReady),
		.airValid(airValid), .airData(airData), .airLast(airLast), .airReady(airReady),
		.rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxIsDest(rxIsDest),
		.rxOutValid(rxOutValid), .rxOutData(rxOutData), .rxDone(rxDone), .rxDrop(rxDrop),
		.rxRelay(rxRelay), .joinReq(joinReq), .joinHasLinkKey(joinHasLinkKey),
		.keyDlvValid(keyDlvValid), .keyDlvData(keyDlvData), .keyDlvEnc(keyDlvEnc),
		.joinDenied(joinDenied), .secEnabled(secEnabled), .leaveNet(leaveNet),
		.rejoinNet(rejoinNet), .txCtr(txCtr), .keySeq(keySeq), .txExhausted(txExhausted),
		.txRefused(txRefused), .maxPayloadQuery(maxPayloadQuery),
		.maxPayloadApsQuery(maxPayloadApsQuery)
	);
	mnse_air_node peer (
		.clk(clk), .airValid(airValid), .airData(airData), .airLast(airLast),
		.airReady(airReady), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (keyDlvValid === 1'b1) begin
			dlvV = 1'b1;
			dlvE = keyDlvEnc;
			dlvD = keyDlvData;
		end
		if (joinDenied === 1'b1) den = 1'b1;
		if (rejoinNet === 1'b1) rejS = 1'b1;
		if (txRefused === 1'b1) refS = 1'b1;
		if (rxOutValid === 1'b1) outQ.push_back(rxOutData);
		if (rxDone === 1'b1) begin
			dropS = rxDrop;
			relS = rxRelay;
		end
		if ((keyDlvValid | joinDenied | rxDone | leaveNet | airValid & airReady & airLast) === 1'b1)
			evN++;
	end
	function automatic logic [63:0] le(input logic [7:0] q[$], input int o, input int n);
		logic [63:0] v;
		v = 64'h0;
		for (int j = n - 1; j >= 0; j--) v = {v[55:0], q[o + j]};
		return v;
	endfunction
	task chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task bail();
		miscompares++;
		$display("unexpected wait expected event seen timeout");
		tally_and_finish();
	endtask
	task waitev();
		int k;
		for (k = 0; k < 400 && evN == evO; k++) @(posedge clk);
		if (evN == evO) bail();
		repeat (2) @(posedge clk);
	endtask
	task txPkt(input logic [2:0] ty, input logic aps, input logic bc, input int n);
		int j, k;
		evO = evN;
		txType <= ty;
		txAps <= aps;
		txBcast <= bc;
		for (j = 0; j < n; j++) begin
			txValid <= 1'b1;
			txData <= 8'ha0 + j[7:0];
			txLast <= j == n - 1;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (txReady !== 1'b1 && k < 200);
			if (txReady !== 1'b1) bail();
		end
		txValid <= 1'b0;
		txLast <= 1'b0;
		waitev();
	endtask
	task rxPkt(input logic [7:0] q[$], input logic dest);
		evO = evN;
		outQ.delete();
		rxIsDest <= dest;
		peer.send(q);
		waitev();
	endtask
	task keyLoad(input logic [127:0] k);
		networkKeySetting <= k;
		networkKeyLoad <= 1'b1;
		@(posedge clk);
		networkKeyLoad <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task joinTry(input logic [127:0] lk, input logic has);
		evO = evN;
		{dlvV, dlvE, den} = 3'h0;
		dlvD = 128'h0;
		linkKeySetting <= lk;
		joinHasLinkKey <= has;
		joinReq <= 1'b1;
		@(posedge clk);
		joinReq <= 1'b0;
		waitev();
	endtask
	initial begin
		{rejS, refS} = 2'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("txReady", txReady, 1'b1);
		chk("maxPayload", maxPayloadQuery, MAX_PL_DEF);
		chk("maxPayloadAps", maxPayloadApsQuery, MAX_PL_DEF - APS_OVH);
		chk("txCtr", txCtr, 32'h0);
		txPkt(FT_DATA, 1'b0, 1'b0, 3);
		chk("plainLen", peer.last.size(), 3);
		for (i = 0; i < 3; i++) chk("plainByte", peer.last[i], 8'ha0 + i[7:0]);
		$display("test plain done");
		evO = evN;
		securityEnableSetting <= 1'b1;
		applyChangesCommand <= 1'b1;
		@(posedge clk);
		applyChangesCommand <= 1'b0;
		waitev();
		chk("secEnabled", secEnabled, 1'b1);
		chk("rejoin", rejS, 1'b1);
		chk("maxPayload", maxPayloadQuery, MAX_PL_DEF - NWK_OVH);
		chk("maxPayloadAps", maxPayloadApsQuery, MAX_PL_DEF - NWK_OVH - APS_OVH);
		keyLoad(NK);
		chk("keySeq", keySeq, 8'h01);
		chk("txCtr", txCtr, 32'h0);
		$display("test enable done");
		for (i = 0; i < 5; i++) begin
			txPkt(i[2:0], 1'b0, 1'b0, 2);
			chk("typeLen", peer.last.size(), i[2:0] == FT_MAC ? 2 : HDR_LEN + 2 + TAG_LEN);
		end
		txPkt(FT_DATA, 1'b0, 1'b0, 4);
		a = peer.last;
		txPkt(FT_DATA, 1'b0, 1'b0, 4);
		b = peer.last;
		chk("secLen", b.size(), HDR_LEN + 4 + TAG_LEN);
		chk("srcAddr", le(b, 4, 8), ownAddr);
		chk("keySeqField", b[12], 8'h01);
		chk("ctrStep", le(b, 0, 4), le(a, 0, 4) + 64'h1);
		txPkt(FT_DATA, 1'b1, 1'b0, 4);
		chk("apsLen", peer.last.size(), HDR_LEN + APS_HDR_LEN + 4 + 2 * TAG_LEN);
		chk("apsFlag", peer.last[13], 8'h01);
		p = peer.last;
		txPkt(FT_DATA, 1'b1, 1'b1, 4);
		chk("bcastLen", peer.last.size(), HDR_LEN + 4 + TAG_LEN);
		chk("bcastFlag", peer.last[13], 8'h02);
		chk("notExhausted", {txExhausted, refS}, 2'h0);
		$display("test transmit done");
		rxPkt(a, 1'b1);
		chk("dropFirst", dropS, 1'b0);
		chk("bodyLen", outQ.size(), 4);
		for (i = 0; i < 4; i++) chk("body", outQ[i], 8'ha0 + i[7:0]);
		rxPkt(b, 1'b1);
		chk("dropNewer", dropS, 1'b0);
		rxPkt(a, 1'b1);
		chk("replay", dropS, 1'b1);
		c = b;
		c[c.size() - 1] = ~c[c.size() - 1];
		rxPkt(c, 1'b1);
		chk("badTag", dropS, 1'b1);
		rxPkt(b, 1'b0);
		chk("relay", {dropS, relS}, 2'h1);
		rxPkt(p, 1'b1);
		chk("apsDrop", dropS, 1'b0);
		chk("apsBodyLen", outQ.size(), 4);
		for (i = 0; i < 4; i++) chk("apsBody", outQ[i], 8'ha0 + i[7:0]);
		$display("test receive done");
		joinTry(128'h0, 1'b0);
		chk("clearKey", {dlvV, dlvE, den}, 3'h4);
		chk("clearData", dlvD, NK);
		joinTry(LK, 1'b1);
		chk("wrapKey", {dlvV, dlvE, den}, 3'h6);
		chk("wrapData", dlvD, NK ^ LK);
		joinTry(LK, 1'b0);
		chk("denied", {dlvV, den}, 2'h1);
		// a node that is not the coordinator hands out no key at all
		isCoordinator <= 1'b0;
		{dlvV, den} = 2'h0;
		joinReq <= 1'b1;
		@(posedge clk);
		joinReq <= 1'b0;
		repeat (3) @(posedge clk);
		chk("routerJoin", {dlvV, den}, 2'h0);
		isCoordinator <= 1'b1;
		keyLoad(128'h0);
		joinTry(128'h0, 1'b0);
		chk("randKey", dlvD != 128'h0 && dlvD != NK, 1'b1);
		chk("keySeq", keySeq, 8'h02);
		$display("test join done");
		tally_and_finish();
	end
endmodule
bind mnse_engine mnse_engine_checker #(.MAX_PL(MAX_PL)) chk_u (
	.clk(clk), .rst_n(rst_n), .securityEnableSetting(securityEnableSetting),
	.applyChangesCommand(applyChangesCommand), .networkKeyLoad(networkKeyLoad),
	.secEnabled(secEnabled), .leaveNet(leaveNet), .rejoinNet(rejoinNet), .txCtr(txCtr),
	.keySeq(keySeq), .maxPayloadQuery(maxPayloadQuery), .maxPayloadApsQuery(maxPayloadApsQuery)
);
